// [cmei_pkg.sv]
// package of register map and field constants for the comparator edge and input control block
package cmei_pkg;
    // register offsets
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_MIRROR = 4'h1;
    localparam logic [3:0] ADDR_STATUS = 4'h2;
    localparam logic [3:0] ADDR_MASK   = 4'h3;
    // control field positions
    localparam int BIT_RISE_EN = 7;
    localparam int BIT_FALL_EN = 6;
    localparam int BIT_PSEL_HI = 5;
    localparam int BIT_PSEL_LO = 4;
    localparam int BIT_MSEL    = 0;
    // writable bits of the control register; bits 3-1 read as zero
    localparam logic [7:0] CTRL_WMASK = 8'hf1;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    // plus input routing codes
    localparam logic [1:0] PSEL_PIN = 2'h0;
    localparam logic [1:0] PSEL_DAC = 2'h1;
    localparam logic [1:0] PSEL_FIX = 2'h2;
    // status bit positions
    localparam int STS_IRQ_FLAG = 0;
endpackage

// [cmei_top.sv]
// comparator edge interrupt and input select logic with register port
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module cmei_top (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // register port
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    output logic      [7:0] rdata,
    // comparator result from the analog side, asynchronous
    input  wire logic       comparator_result_bit,
    // analog mux steering
    output logic      [2:0] plus_sel_onehot,
    output logic            minus_sel_one,
    // interrupt
    output logic            comparator_irq_flag,
    output logic            irq
);
    logic [7:0] ctrl_r;
    logic [7:0] mask_r;
    logic       flag_r;
    logic       sync1_r;
    logic       sync2_r;
    logic       prev_r;
    logic       rise_evt;
    logic       fall_evt;
    logic       edge_evt;
    logic       flag_clr;
    logic [2:0] hist_fill_r;
    logic       hist_ok;

    // register write hit; the same decode serves every writable place
    function automatic logic wr_hit(
        input logic       we,
        input logic [3:0] a,
        input logic [3:0] place
    );
        return we && (a == place);
    endfunction

    // control register write; reserved bits never store
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            ctrl_r <= cmei_pkg::CTRL_RESET;
        else if (wr_hit(wr_en, addr, cmei_pkg::ADDR_CTRL))
            ctrl_r <= wdata & cmei_pkg::CTRL_WMASK;
    end

    // mask register write
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            mask_r <= cmei_pkg::MASK_RESET;
        else if (wr_hit(wr_en, addr, cmei_pkg::ADDR_MASK))
            mask_r <= wdata;
    end

    // two-flop synchroniser, then one more stage for edge history
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r  <= 1'b0;
        end
        else
        begin
            sync1_r <= comparator_result_bit;
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    // history fill tracker; prev_r holds a real sample only after three edges,
    // so a result already high at release is not mistaken for a fresh edge
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            hist_fill_r <= 3'h0;
        else
            hist_fill_r <= {hist_fill_r[1:0], 1'b1};
    end

    // edge qualification by the enable bits; no edge counts until the history is real
    assign hist_ok  = hist_fill_r[2];
    assign rise_evt = sync2_r & ~prev_r & hist_ok
                      & ctrl_r[cmei_pkg::BIT_RISE_EN];
    assign fall_evt = ~sync2_r & prev_r & hist_ok
                      & ctrl_r[cmei_pkg::BIT_FALL_EN];
    assign edge_evt = rise_evt | fall_evt;
    assign flag_clr = wr_hit(wr_en, addr, cmei_pkg::ADDR_STATUS)
                      && wdata[cmei_pkg::STS_IRQ_FLAG];

    // sticky flag; a new edge wins over a same-cycle clear so no event is lost
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            flag_r <= 1'b0;
        else if (edge_evt)
            flag_r <= 1'b1;
        else if (flag_clr)
            flag_r <= 1'b0;
    end

    // read data, registered one cycle after the strobe
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            rdata <= 8'h00;
        else if (rd_en)
        begin
            case (addr)
                cmei_pkg::ADDR_CTRL:   rdata <= ctrl_r;
                cmei_pkg::ADDR_MIRROR: rdata <= {7'h00, sync2_r};
                cmei_pkg::ADDR_STATUS: rdata <= {7'h00, flag_r};
                cmei_pkg::ADDR_MASK:   rdata <= mask_r;
                default:               rdata <= 8'h00;
            endcase
        end
        else
            rdata <= 8'h00;
    end

    // plus input routing; code 11 selects nothing to avoid shorting sources
    always_comb
    begin
        case (ctrl_r[cmei_pkg::BIT_PSEL_HI:cmei_pkg::BIT_PSEL_LO])
            cmei_pkg::PSEL_PIN: plus_sel_onehot = 3'h1;
            cmei_pkg::PSEL_DAC: plus_sel_onehot = 3'h2;
            cmei_pkg::PSEL_FIX: plus_sel_onehot = 3'h4;
            default:            plus_sel_onehot = 3'h0;
        endcase
    end

    // minus routing and interrupt outputs
    assign minus_sel_one       = ctrl_r[cmei_pkg::BIT_MSEL];
    assign comparator_irq_flag = flag_r;
    assign irq                 = flag_r & mask_r[cmei_pkg::STS_IRQ_FLAG];

    // assertions
    property p_no_rise_when_off;
        @(posedge clk) disable iff (!reset_n)
        (sync2_r && !prev_r && !ctrl_r[7] && !flag_r && !(fall_evt)) |=> !flag_r;
    endproperty
    a_no_rise_when_off: assert property (p_no_rise_when_off) else $error("rise flagged while off");

    property p_fall_sets;
        @(posedge clk) disable iff (!reset_n)
        (!sync2_r && prev_r && ctrl_r[6]) |=> flag_r;
    endproperty
    a_fall_sets: assert property (p_fall_sets) else $error("falling edge not flagged");

    property p_no_fall_when_off;
        @(posedge clk) disable iff (!reset_n)
        (!sync2_r && prev_r && !ctrl_r[6] && !flag_r) |=> !flag_r;
    endproperty
    a_no_fall_when_off: assert property (p_no_fall_when_off) else $error("fall flagged while off");

    property p_plus_route;
        @(posedge clk) disable iff (!reset_n)
        $onehot0(plus_sel_onehot)
            && (plus_sel_onehot[0] == (ctrl_r[5:4] == cmei_pkg::PSEL_PIN))
            && (plus_sel_onehot[1] == (ctrl_r[5:4] == cmei_pkg::PSEL_DAC))
            && (plus_sel_onehot[2] == (ctrl_r[5:4] == cmei_pkg::PSEL_FIX));
    endproperty
    a_plus_route: assert property (p_plus_route) else $error("plus route wrong");

    property p_minus_route;
        @(posedge clk) disable iff (!reset_n)
        (wr_en && addr == 4'h0) |=> (minus_sel_one == $past(wdata[0]));
    endproperty
    a_minus_route: assert property (p_minus_route) else $error("minus route wrong");

    property p_mirror;
        @(posedge clk) disable iff (!reset_n)
        (rd_en && addr == 4'h1) |=> (rdata == {7'h00, $past(sync2_r)});
    endproperty
    a_mirror: assert property (p_mirror) else $error("mirror read wrong");

    property p_rise_sets;
        @(posedge clk) disable iff (!reset_n)
        (sync2_r && !prev_r && hist_ok && ctrl_r[cmei_pkg::BIT_RISE_EN]) |=> flag_r;
    endproperty
    a_rise_sets: assert property (p_rise_sets) else $error("rising edge not flagged");

    property p_input_to_flag;
        @(posedge clk) disable iff (!reset_n)
        ($rose(sync1_r) && prev_r == 1'b0 && sync2_r == 1'b0 && ctrl_r[7]
            && hist_ok && !(wr_en && addr == cmei_pkg::ADDR_CTRL)) |-> ##2 flag_r;
    endproperty
    a_input_to_flag: assert property (p_input_to_flag) else $error("flag latency wrong");

    property p_irq_level;
        @(posedge clk) disable iff (!reset_n)
        irq == (flag_r && mask_r[cmei_pkg::STS_IRQ_FLAG]);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq does not follow flag and mask");

    property p_clear_works;
        @(posedge clk) disable iff (!reset_n)
        (flag_clr && !edge_evt) |=> !flag_r;
    endproperty
    a_clear_works: assert property (p_clear_works) else $error("flag not cleared");

    property p_edge_beats_clear;
        @(posedge clk) disable iff (!reset_n)
        (flag_clr && edge_evt) |=> flag_r;
    endproperty
    a_edge_beats_clear: assert property (p_edge_beats_clear)
        else $error("edge lost to a same-cycle clear");

    property p_quiet_after_reset;
        @(posedge clk) disable iff (!reset_n)
        (!hist_ok && !flag_r) |=> !flag_r;
    endproperty
    a_quiet_after_reset: assert property (p_quiet_after_reset)
        else $error("edge flagged before history filled");

    property p_rdata_idle;
        @(posedge clk) disable iff (!reset_n)
        !rd_en |=> (rdata == 8'h00);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

    property p_reserved_zero;
        @(posedge clk) disable iff (!reset_n)
        (ctrl_r & ~cmei_pkg::CTRL_WMASK) == 8'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

    c_rise: cover property (@(posedge clk) disable iff (!reset_n) rise_evt);
    c_fall: cover property (@(posedge clk) disable iff (!reset_n) fall_evt);
    c_clear: cover property (@(posedge clk) disable iff (!reset_n) flag_r && flag_clr ##1 !flag_r);
    c_irq: cover property (@(posedge clk) disable iff (!reset_n) $rose(irq));
    c_collide: cover property (@(posedge clk) disable iff (!reset_n) edge_evt && flag_clr);
endmodule

// [tb_top.sv]
// self-checking testbench for the comparator edge interrupt and input select block
`timescale 1ns/1ps
module tb_top;
    logic       clk     = 1'b0;
    logic       reset_n = 1'b0;
    logic [3:0] addr    = 4'h0;
    logic [7:0] wdata   = 8'h00;
    logic       wr_en   = 1'b0;
    logic       rd_en   = 1'b0;
    logic       comp    = 1'b0;
    logic [7:0] rdata;
    logic [2:0] psel;
    logic       msel;
    logic       flag;
    logic       irq;
    int         err_total = 0;
    int         n_checks  = 0;

    // 100 MHz system clock
    always #5 clk = ~clk;

    cmei_top i_dut (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .comparator_result_bit(comp), .plus_sel_onehot(psel),
        .minus_sel_one(msel), .comparator_irq_flag(flag), .irq(irq));

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        n_checks++;
        if (s !== e)
        begin
            $display("BAD %s expected %h seen %h", nm, e, s);
            err_total++;
        end
    endtask

    // one-cycle write strobe; outputs are looked at once the update edge has landed
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr_en <= 1'b0;
        #1;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        rd_en <= 1'b1;
        addr  <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk("rdata", e, rdata);
    endtask

    // two synchroniser flops plus the flag edge, then one spare cycle
    task automatic settle(input logic v);
        @(posedge clk);
        comp <= v;
        repeat (4) @(posedge clk);
        #1;
    endtask

    task automatic t_reset;
        chk("psel", 8'h01, {5'h00, psel});
        chk("flag", 8'h00, {6'h00, flag, irq});
        rd(cmei_pkg::ADDR_CTRL, cmei_pkg::CTRL_RESET);
        rd(cmei_pkg::ADDR_MIRROR, 8'h00);
        rd(cmei_pkg::ADDR_MASK, cmei_pkg::MASK_RESET);
        rd(4'h7, 8'h00); // unmapped place reads zero
        $display("test reset done");
    endtask

    task automatic t_route;
        logic [1:0] c;
        for (int i = 0; i < 4; i++)
        begin
            c = i[1:0];
            wr(cmei_pkg::ADDR_CTRL, {2'b00, c, 3'b111, c[0]});
            chk("psel", (c == 2'h3) ? 8'h00 : 8'h01 << c, {5'h00, psel});
            chk("msel", {7'h00, c[0]}, {7'h00, msel});
            rd(cmei_pkg::ADDR_CTRL, {2'b00, c, 3'b111, c[0]} & cmei_pkg::CTRL_WMASK);
        end
        wr(cmei_pkg::ADDR_CTRL, 8'h00);
        $display("test route done");
    endtask

    task automatic t_edges;
        wr(cmei_pkg::ADDR_MASK, 8'h01);
        settle(1'b1);
        chk("flag", 8'h00, {7'h00, flag});
        rd(cmei_pkg::ADDR_MIRROR, 8'h01);
        settle(1'b0);
        chk("flag", 8'h00, {7'h00, flag});
        wr(cmei_pkg::ADDR_CTRL, 8'h80);
        settle(1'b1);
        chk("flag_irq", 8'h03, {6'h00, flag, irq});
        wr(cmei_pkg::ADDR_STATUS, 8'h01);
        chk("flag", 8'h00, {7'h00, flag});
        wr(cmei_pkg::ADDR_CTRL, 8'h40);
        settle(1'b0);
        chk("flag", 8'h01, {7'h00, flag});
        rd(cmei_pkg::ADDR_MIRROR, 8'h00);
        rd(cmei_pkg::ADDR_STATUS, 8'h01);
        wr(cmei_pkg::ADDR_MASK, 8'h00);
        chk("irq", 8'h00, {7'h00, irq});
        wr(cmei_pkg::ADDR_STATUS, 8'h01);
        settle(1'b1);
        chk("flag", 8'h00, {7'h00, flag});
        $display("test edges done");
    endtask

    // a result already high when reset lets go is not an edge; rise is enabled at
    // once so that a false edge from the reset history would land on the flag
    task automatic t_rearm;
        @(posedge clk);
        comp    <= 1'b1;
        reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        #1;
        chk("outputs_after_reset", 8'h01, {2'h0, flag, irq, msel, psel});
        wr(cmei_pkg::ADDR_CTRL, 8'hc0);
        repeat (4) @(posedge clk);
        #1;
        chk("flag", 8'h00, {7'h00, flag});
        rd(cmei_pkg::ADDR_MIRROR, 8'h01);
        $display("test rearm done");
    endtask

    // an edge and a flag clear meeting in one cycle: the edge wins
    task automatic t_collide;
        settle(1'b0);
        chk("flag", 8'h01, {7'h00, flag});
        @(posedge clk);
        comp  <= 1'b1;
        repeat (2) @(posedge clk);
        wr_en <= 1'b1;
        addr  <= cmei_pkg::ADDR_STATUS;
        wdata <= 8'h01;
        @(posedge clk);
        wr_en <= 1'b0;
        #1;
        chk("flag", 8'h01, {7'h00, flag});
        wr(cmei_pkg::ADDR_STATUS, 8'h01);
        chk("flag", 8'h00, {7'h00, flag});
        $display("test collide done");
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // hang guard
    initial
    begin
        #100000;
        err_total++;
        conclude();
    end

    initial
    begin
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        #1;
        t_reset();
        t_route();
        t_edges();
        t_rearm();
        t_collide();
        conclude();
    end
endmodule
